// ===== pps_bit_map.sv
/*
  status/control bit mapper: reorders per-port channel bits into the cyclic
  image, interleaved or grouped.
  assumes: purely combinational, driven from the top on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pps_bit_map #(
  parameter int PORTS = 8
) (
  input wire logic grouped_i,
  input wire logic [PORTS-1:0] ch_a_i,
  input wire logic [PORTS-1:0] ch_b_i,
  output logic [2*PORTS-1:0] image_o
);

  // --------------------------------------------------------------
  // mapping
  // --------------------------------------------------------------
  // interleaved: a0 b0 a1 b1 ...; grouped: a0..an then b0..bn
  always_comb begin
    image_o = '0;
    for (int p = 0; p < PORTS; p++) begin
      if (grouped_i) begin
        image_o[p] = ch_a_i[p];
        image_o[PORTS+p] = ch_b_i[p];
      end else begin
        image_o[2*p] = ch_a_i[p];
        image_o[2*p+1] = ch_b_i[p];
      end
    end
  end

endmodule
`default_nettype wire

// ===== pps_dev_model.sv
/*
  model of the attached device: identity, upload flag and storage transfers.
  assumes: busy_i high while the master asks for a transfer.
*/
`timescale 1ns/1ps
`default_nettype none
module pps_dev_model #(
  parameter logic [15:0] VENDOR = 16'hA1B2, // arbitrary value
  parameter logic [15:0] DEVICE = 16'hC3D4 // arbitrary value
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic blk_wr_i,
  input wire logic busy_i,
  input wire logic [3:0] lag_i,
  output logic [15:0] vendor_o,
  output logic [15:0] devid_o,
  output logic flag_o,
  output logic done_o
);
  logic [3:0] cnt_reg, cnt_next;
  logic fired_reg, fired_next, done_next, flag_next;
  assign vendor_o = VENDOR;
  assign devid_o = DEVICE;
  // transfer ends lag_i+1 cycles after busy_i rises, one done pulse each
  always_comb begin
    done_next = busy_i && !fired_reg && cnt_reg == lag_i;
    fired_next = busy_i && (fired_reg || done_next);
    cnt_next = (busy_i && !fired_next) ? cnt_reg + 4'h1 : 4'h0;
    flag_next = blk_wr_i || (flag_o && !done_next);
  end
  // register transfer state
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 4'h0;
      fired_reg <= 1'b0;
      done_o <= 1'b0;
      flag_o <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      fired_reg <= fired_next;
      done_o <= done_next;
      flag_o <= flag_next;
    end
  end
endmodule
`default_nettype wire

// ===== pps_pkg.sv
/*
  package for the port parameter-storage / fail-safe block: selector encodings,
  widths and fixed values.
  assumes: single clock domain, no register bus.
*/
package pps_pkg;

  // parameter storage selector
  typedef enum logic [2:0] {
    PPS_DS_DISABLED,
    PPS_DS_DOWNLOAD,
    PPS_DS_UPLOAD,
    PPS_DS_BOTH,
    PPS_DS_CLEARED
  } pps_ds_mode_t;

  // device validation selector
  typedef enum logic [1:0] {
    PPS_VAL_NONE,
    PPS_VAL_COMPAT,
    PPS_VAL_IDENT
  } pps_val_mode_t;

  // fail-safe selector
  typedef enum logic [2:0] {
    PPS_FS_LOW,
    PPS_FS_HIGH,
    PPS_FS_HOLD,
    PPS_FS_REPL,
    PPS_FS_MCMD
  } pps_fs_mode_t;

  // storage decision
  typedef enum logic [1:0] {
    PPS_ACT_NONE,
    PPS_ACT_UPLOAD,
    PPS_ACT_DOWNLOAD
  } pps_act_t;

  // port operating states
  typedef enum logic [1:0] {
    PPS_PORT_OTHER,
    PPS_PORT_COM
  } pps_port_t;

  // store-and-upload command coordinates
  localparam logic [15:0] PPS_CMD_INDEX = 16'h0002;
  localparam logic [7:0] PPS_CMD_SUBINDEX = 8'h00;
  localparam logic [7:0] PPS_CMD_VALUE = 8'h05;

  // identity and serial sizes
  localparam int PPS_ID_BYTES = 2;
  localparam int PPS_SERIAL_CHARS = 16;
  localparam int PPS_SC_BYTES = 4;
  localparam int PPS_PORTS = 8;

  // arbitrary neutral identity defaults
  localparam logic [15:0] PPS_DEF_VENDOR = 16'h1234;
  localparam logic [15:0] PPS_DEF_DEVICE = 16'h5678;

endpackage

// ===== pps_port_ctrl.sv
/*
  per-port control of an IO-Link master port: parameter storage decision,
  identity validation, fail-safe output selection, and the cyclic status/control
  image with two bit-mapping modes.
  assumes: configuration and cyclic data come from the fieldbus side, device
  facts come from the IO-Link stack; all on mclk_i.
*/
// What this block does
// - upload-only mode with no valid stored set: upload on connection.
// - store-and-upload command sets device upload flag; master then uploads and overwrites.
// - combined mode keeps uploaded data in non-volatile storage.
// - combined mode compares on connect; download on difference unless device locked.
// - upload if own data invalid and device valid, or upload flag set.
// - clearing mode disables storage and erases the stored set.
// - validation off: start communication without identity checks.
// - compatible validation: vendor and device codes must match to start.
// - identical validation additionally requires the serial number to match.
// - configured vendor and device codes are two bytes, high byte first.
// - configured serial number is a string of at most 16 characters.
// - fail-safe substitution only for COM ports carrying output data.
// - fail-safe low sends all zeros (default); high sends all ones.
// - hold-last keeps sending the last valid controller output cyclically.
// - replacement sends a configured value, most significant part first.
// - master-command choice flags output data invalid to the device.
// - status/control image is 4 bytes in and 4 bytes out.
// - interleaved mapping alternates channel bits per port, ascending.
// - grouped mapping lists all first-channel bits then all second-channel bits.
// - status/control settings not about COM ports are always accepted.
// - download-only mode compares and downloads on difference unless locked.
// - storage defaults to disabled; disabling keeps stored data.
`timescale 1ns/1ps
`default_nettype none
module pps_port_ctrl #(
  parameter int PD_BYTES = 32,
  parameter int PORTS = pps_pkg::PPS_PORTS
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  // configuration
  input wire logic [2:0] cfg_ds_mode_i,
  input wire logic [1:0] cfg_val_mode_i,
  input wire logic [2:0] cfg_fs_mode_i,
  input wire logic cfg_com_mode_i,
  input wire logic cfg_grouped_i,
  input wire logic [7:0] cfg_vendor_hi_i,
  input wire logic [7:0] cfg_vendor_lo_i,
  input wire logic [7:0] cfg_devid_hi_i,
  input wire logic [7:0] cfg_devid_lo_i,
  input wire logic [8*pps_pkg::PPS_SERIAL_CHARS-1:0] cfg_serial_i,
  input wire logic [8*PD_BYTES-1:0] cfg_repl_i,
  input wire logic cfg_load_i,
  // device facts
  input wire logic dev_connect_i,
  input wire logic [15:0] dev_vendor_i,
  input wire logic [15:0] dev_devid_i,
  input wire logic [8*pps_pkg::PPS_SERIAL_CHARS-1:0] dev_serial_i,
  input wire logic dev_valid_i,
  input wire logic dev_upload_request_flag_i,
  input wire logic dev_locked_i,
  input wire logic dev_data_differs_i,
  input wire logic ds_done_i,
  // acyclic write seen on the port
  input wire logic acyc_wr_i,
  input wire logic [15:0] acyc_index_i,
  input wire logic [7:0] acyc_subindex_i,
  input wire logic [7:0] acyc_value_i,
  // cyclic data from controller
  input wire logic ctl_valid_i,
  input wire logic [8*PD_BYTES-1:0] ctl_pd_out_i,
  input wire logic [8*pps_pkg::PPS_SC_BYTES-1:0] ctl_sc_out_i,
  input wire logic [PORTS-1:0] pin_ch_a_i,
  input wire logic [PORTS-1:0] pin_ch_b_i,
  input wire logic [15:0] master_status_i,
  // results
  output logic ds_upload_o,
  output logic ds_download_o,
  output logic store_valid_o,
  output logic store_nv_o,
  output logic pd_start_o,
  output logic val_fail_o,
  output logic [8*PD_BYTES-1:0] pd_out_o,
  output logic pd_out_invalid_o,
  output logic [8*pps_pkg::PPS_SC_BYTES-1:0] sc_in_o,
  output logic [PORTS-1:0] do_ch_a_o,
  output logic [PORTS-1:0] do_ch_b_o
);

  localparam int PDW = 8 * PD_BYTES;
  localparam int SCW = 8 * pps_pkg::PPS_SC_BYTES;

  // refuse sizes the image and data path cannot serve
  if (PD_BYTES < 1 || PD_BYTES > 32 || 2 * PORTS > SCW / 2) begin : g_bad_size
    $error("pps_port_ctrl size parameters out of range");
  end

  // --------------------------------------------------------------
  // input synchronisers for pins
  // --------------------------------------------------------------
  logic [PORTS-1:0] pa_s1_reg, pa_s2_reg, pb_s1_reg, pb_s2_reg;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pa_s1_reg <= '0;
      pa_s2_reg <= '0;
      pb_s1_reg <= '0;
      pb_s2_reg <= '0;
    end else begin
      pa_s1_reg <= pin_ch_a_i;
      pa_s2_reg <= pa_s1_reg;
      pb_s1_reg <= pin_ch_b_i;
      pb_s2_reg <= pb_s1_reg;
    end
  end

  // --------------------------------------------------------------
  // latched configuration
  // --------------------------------------------------------------
  pps_pkg::pps_ds_mode_t ds_mode_reg, ds_mode_next;
  pps_pkg::pps_val_mode_t val_mode_reg, val_mode_next;
  pps_pkg::pps_fs_mode_t fs_mode_reg, fs_mode_next;
  logic com_reg, com_next;
  logic grouped_reg, grouped_next;
  logic [15:0] vendor_reg, vendor_next;
  logic [15:0] devid_reg, devid_next;
  logic [8*pps_pkg::PPS_SERIAL_CHARS-1:0] serial_reg, serial_next;
  logic [PDW-1:0] repl_reg, repl_next;

  // latch selectors only on a load while port is not communicating; grouped mapping follows cfg_grouped_i every cycle
  always_comb begin
    ds_mode_next = ds_mode_reg;
    val_mode_next = val_mode_reg;
    fs_mode_next = fs_mode_reg;
    com_next = com_reg;
    grouped_next = cfg_grouped_i;
    vendor_next = vendor_reg;
    devid_next = devid_reg;
    serial_next = serial_reg;
    repl_next = repl_reg;
    if (cfg_load_i && !dev_connect_i) begin
      ds_mode_next = pps_pkg::pps_ds_mode_t'(cfg_ds_mode_i);
      val_mode_next = pps_pkg::pps_val_mode_t'(cfg_val_mode_i);
      fs_mode_next = pps_pkg::pps_fs_mode_t'(cfg_fs_mode_i);
      com_next = cfg_com_mode_i;
      vendor_next = {cfg_vendor_hi_i, cfg_vendor_lo_i};
      devid_next = {cfg_devid_hi_i, cfg_devid_lo_i};
      serial_next = cfg_serial_i;
      repl_next = cfg_repl_i; // first byte is most significant
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ds_mode_reg <= pps_pkg::PPS_DS_DISABLED;
      val_mode_reg <= pps_pkg::PPS_VAL_NONE;
      fs_mode_reg <= pps_pkg::PPS_FS_LOW;
      com_reg <= 1'b0;
      grouped_reg <= 1'b0;
      vendor_reg <= pps_pkg::PPS_DEF_VENDOR;
      devid_reg <= pps_pkg::PPS_DEF_DEVICE;
      serial_reg <= '0;
      repl_reg <= '0;
    end else begin
      ds_mode_reg <= ds_mode_next;
      val_mode_reg <= val_mode_next;
      fs_mode_reg <= fs_mode_next;
      com_reg <= com_next;
      grouped_reg <= grouped_next;
      vendor_reg <= vendor_next;
      devid_reg <= devid_next;
      serial_reg <= serial_next;
      repl_reg <= repl_next;
    end
  end

  // --------------------------------------------------------------
  // parameter storage
  // --------------------------------------------------------------
  logic conn_d_reg, conn_d_next;
  logic store_valid_reg, store_valid_next;
  logic store_nv_reg, store_nv_next;
  logic up_req_reg, up_req_next;
  logic ds_up_reg, ds_up_next;
  logic ds_dn_reg, ds_dn_next;
  logic connect_edge, cmd_hit, up_mode, dn_mode;

  assign connect_edge = dev_connect_i && !conn_d_reg;
  assign cmd_hit = acyc_wr_i && acyc_index_i == pps_pkg::PPS_CMD_INDEX &&
                   acyc_subindex_i == pps_pkg::PPS_CMD_SUBINDEX &&
                   acyc_value_i == pps_pkg::PPS_CMD_VALUE;
  assign up_mode = ds_mode_reg == pps_pkg::PPS_DS_UPLOAD || ds_mode_reg == pps_pkg::PPS_DS_BOTH;
  assign dn_mode = ds_mode_reg == pps_pkg::PPS_DS_DOWNLOAD || ds_mode_reg == pps_pkg::PPS_DS_BOTH;

  // decide upload or download on connect or on upload flag
  always_comb begin
    conn_d_next = dev_connect_i;
    store_valid_next = store_valid_reg;
    store_nv_next = store_nv_reg;
    up_req_next = up_req_reg;
    ds_up_next = ds_up_reg;
    ds_dn_next = ds_dn_reg;
    if (ds_done_i) begin
      if (ds_up_reg) begin
        store_valid_next = 1'b1; // overwrite stored set
        store_nv_next = ds_mode_reg == pps_pkg::PPS_DS_BOTH;
      end
      ds_up_next = 1'b0;
      ds_dn_next = 1'b0;
      up_req_next = 1'b0;
    end
    // set wins over the clear above
    if (cmd_hit && up_mode) begin
      up_req_next = 1'b1;
    end
    if (dev_connect_i && up_mode && (up_req_next || dev_upload_request_flag_i) && !ds_dn_reg) begin
      ds_up_next = 1'b1;
    end
    if (connect_edge) begin
      if (up_mode && !store_valid_reg && dev_valid_i) begin
        ds_up_next = 1'b1;
      end else if (dn_mode && store_valid_reg && !dev_upload_request_flag_i && !up_req_reg &&
                   dev_data_differs_i && !dev_locked_i) begin
        ds_dn_next = 1'b1;
      end
    end
    if (ds_mode_reg == pps_pkg::PPS_DS_CLEARED) begin
      store_valid_next = 1'b0;
      store_nv_next = 1'b0;
      ds_up_next = 1'b0;
      ds_dn_next = 1'b0;
      up_req_next = 1'b0;
    end else if (ds_mode_reg == pps_pkg::PPS_DS_DISABLED) begin
      ds_up_next = 1'b0; // stored set untouched
      ds_dn_next = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conn_d_reg <= 1'b0;
      store_valid_reg <= 1'b0;
      store_nv_reg <= 1'b0;
      up_req_reg <= 1'b0;
      ds_up_reg <= 1'b0;
      ds_dn_reg <= 1'b0;
    end else begin
      conn_d_reg <= conn_d_next;
      store_valid_reg <= store_valid_next;
      store_nv_reg <= store_nv_next;
      up_req_reg <= up_req_next;
      ds_up_reg <= ds_up_next;
      ds_dn_reg <= ds_dn_next;
    end
  end

  // --------------------------------------------------------------
  // identity validation
  // --------------------------------------------------------------
  logic start_reg, start_next;
  logic fail_reg, fail_next;
  logic id_ok, sn_ok, pass;

  assign id_ok = dev_vendor_i == vendor_reg && dev_devid_i == devid_reg;
  assign sn_ok = dev_serial_i == serial_reg;

  always_comb begin
    unique case (val_mode_reg)
      pps_pkg::PPS_VAL_NONE: pass = 1'b1;
      pps_pkg::PPS_VAL_COMPAT: pass = id_ok;
      pps_pkg::PPS_VAL_IDENT: pass = id_ok && sn_ok;
      default: pass = 1'b0;
    endcase
  end

  // checked once per connection, held until disconnect
  always_comb begin
    start_next = start_reg;
    fail_next = fail_reg;
    if (!dev_connect_i) begin
      start_next = 1'b0;
      fail_next = 1'b0;
    end else if (connect_edge) begin
      start_next = pass;
      fail_next = !pass;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else begin
      start_reg <= start_next;
      fail_reg <= fail_next;
    end
  end

  // --------------------------------------------------------------
  // fail-safe output selection
  // --------------------------------------------------------------
  logic [PDW-1:0] last_reg, last_next;
  logic [PDW-1:0] pd_reg, pd_next;
  logic pd_inv_reg, pd_inv_next;

  always_comb begin
    last_next = ctl_valid_i ? ctl_pd_out_i : last_reg;
    pd_next = ctl_pd_out_i;
    pd_inv_next = 1'b0;
    if (!com_reg) begin
      pd_next = '0; // no output data outside COM mode
    end else if (!ctl_valid_i) begin
      unique case (fs_mode_reg)
        pps_pkg::PPS_FS_LOW: pd_next = '0;
        pps_pkg::PPS_FS_HIGH: pd_next = '1;
        pps_pkg::PPS_FS_HOLD: pd_next = last_reg;
        pps_pkg::PPS_FS_REPL: pd_next = repl_reg;
        pps_pkg::PPS_FS_MCMD: begin
          pd_next = last_reg;
          pd_inv_next = 1'b1;
        end
        default: pd_next = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_reg <= '0;
      pd_reg <= '0;
      pd_inv_reg <= 1'b0;
    end else begin
      last_reg <= last_next;
      pd_reg <= pd_next;
      pd_inv_reg <= pd_inv_next;
    end
  end

  // --------------------------------------------------------------
  // status/control image
  // --------------------------------------------------------------
  logic [2*PORTS-1:0] in_bits;
  logic [SCW-1:0] sc_reg, sc_next;
  logic [PORTS-1:0] da_reg, da_next, db_reg, db_next;

  pps_bit_map #(.PORTS(PORTS)) u_map (
    .grouped_i(grouped_reg),
    .ch_a_i(pa_s2_reg),
    .ch_b_i(pb_s2_reg),
    .image_o(in_bits)
  );

  // input image: digital bits low half, master status high half
  always_comb begin
    sc_next = '0;
    sc_next[2*PORTS-1:0] = in_bits;
    sc_next[SCW-1:SCW-16] = master_status_i;
    for (int p = 0; p < PORTS; p++) begin
      if (grouped_reg) begin
        da_next[p] = ctl_sc_out_i[p];
        db_next[p] = ctl_sc_out_i[PORTS+p];
      end else begin
        da_next[p] = ctl_sc_out_i[2*p];
        db_next[p] = ctl_sc_out_i[2*p+1];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sc_reg <= '0;
      da_reg <= '0;
      db_reg <= '0;
    end else begin
      sc_reg <= sc_next;
      da_reg <= da_next;
      db_reg <= db_next;
    end
  end

  assign ds_upload_o = ds_up_reg;
  assign ds_download_o = ds_dn_reg;
  assign store_valid_o = store_valid_reg;
  assign store_nv_o = store_nv_reg;
  assign pd_start_o = start_reg;
  assign val_fail_o = fail_reg;
  assign pd_out_o = pd_reg;
  assign pd_out_invalid_o = pd_inv_reg;
  assign sc_in_o = sc_reg;
  assign do_ch_a_o = da_reg;
  assign do_ch_b_o = db_reg;

endmodule
`default_nettype wire

// ===== pps_port_ctrl_asserts.sv
/*
  checker for pps_port_ctrl: storage requests, validation start, fail-safe
  output selection and status image timing.
  assumes: bound to pps_port_ctrl, one clock mclk_i, reset nrst_i low.
*/
`timescale 1ns/1ps
`default_nettype none
module pps_port_ctrl_chk #(
  parameter int PD_BYTES = 32
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [2:0] cfg_ds_mode_i,
  input wire logic [1:0] cfg_val_mode_i,
  input wire logic [2:0] cfg_fs_mode_i,
  input wire logic cfg_com_mode_i,
  input wire logic [8*PD_BYTES-1:0] cfg_repl_i,
  input wire logic cfg_load_i,
  input wire logic dev_connect_i,
  input wire logic dev_valid_i,
  input wire logic dev_upload_request_flag_i,
  input wire logic dev_locked_i,
  input wire logic dev_data_differs_i,
  input wire logic ctl_valid_i,
  input wire logic [8*PD_BYTES-1:0] ctl_pd_out_i,
  input wire logic [15:0] master_status_i,
  input wire logic ds_upload_o,
  input wire logic ds_download_o,
  input wire logic store_valid_o,
  input wire logic pd_start_o,
  input wire logic [8*PD_BYTES-1:0] pd_out_o,
  input wire logic pd_out_invalid_o,
  input wire logic [31:0] sc_in_o
);
  // ----------------------------------------
  // copy of the selectors on a legal load
  // ----------------------------------------
  logic [2:0] ds_reg, ds_next, fs_reg, fs_next;
  logic [1:0] val_reg, val_next;
  logic com_reg, com_next, take;
  logic [8*PD_BYTES-1:0] repl_reg, repl_next;
  assign take = cfg_load_i && !dev_connect_i;
  // loads while connected are ignored
  always_comb begin
    ds_next = take ? cfg_ds_mode_i : ds_reg;
    fs_next = take ? cfg_fs_mode_i : fs_reg;
    val_next = take ? cfg_val_mode_i : val_reg;
    com_next = take ? cfg_com_mode_i : com_reg;
    repl_next = take ? cfg_repl_i : repl_reg;
  end
  // register the copy
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ds_reg <= '0;
      fs_reg <= '0;
      val_reg <= '0;
      com_reg <= 1'b0;
      repl_reg <= '0;
    end else begin
      ds_reg <= ds_next;
      fs_reg <= fs_next;
      val_reg <= val_next;
      com_reg <= com_next;
      repl_reg <= repl_next;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_fs_pass; com_reg && ctl_valid_i |=> pd_out_o == $past(ctl_pd_out_i); endproperty
  a_fs_pass: assert property (p_fs_pass) else $error("pd out not passed");
  property p_fs_off; !com_reg |=> pd_out_o == '0; endproperty
  a_fs_off: assert property (p_fs_off) else $error("pd out not zero off com");
  property p_fs_low; com_reg && !ctl_valid_i && fs_reg == pps_pkg::PPS_FS_LOW |=> pd_out_o == '0; endproperty
  a_fs_low: assert property (p_fs_low) else $error("fail-safe low wrong");
  property p_fs_high; com_reg && !ctl_valid_i && fs_reg == pps_pkg::PPS_FS_HIGH |=> &pd_out_o; endproperty
  a_fs_high: assert property (p_fs_high) else $error("fail-safe high wrong");
  property p_fs_repl; com_reg && !ctl_valid_i && fs_reg == pps_pkg::PPS_FS_REPL |=> pd_out_o == $past(repl_reg); endproperty
  a_fs_repl: assert property (p_fs_repl) else $error("replacement wrong");
  property p_mcmd; com_reg && !ctl_valid_i && fs_reg == pps_pkg::PPS_FS_MCMD |=> pd_out_invalid_o; endproperty
  a_mcmd: assert property (p_mcmd) else $error("invalid flag missing");
  property p_status; 1'b1 |=> sc_in_o[31:16] == $past(master_status_i); endproperty
  a_status: assert property (p_status) else $error("status half wrong");
  property p_upl;
    $rose(dev_connect_i) && ds_reg == pps_pkg::PPS_DS_UPLOAD && !store_valid_o && dev_valid_i |=> ds_upload_o;
  endproperty
  a_upl: assert property (p_upl) else $error("upload not requested");
  property p_dl;
    $rose(dev_connect_i) && (ds_reg == pps_pkg::PPS_DS_DOWNLOAD || ds_reg == pps_pkg::PPS_DS_BOTH) && store_valid_o
      && !dev_upload_request_flag_i && dev_data_differs_i && !dev_locked_i |=> ds_download_o;
  endproperty
  a_dl: assert property (p_dl) else $error("download not requested");
  property p_clr; ds_reg == pps_pkg::PPS_DS_CLEARED |=> !store_valid_o && !ds_upload_o && !ds_download_o; endproperty
  a_clr: assert property (p_clr) else $error("cleared mode not empty");
  property p_keep; ds_reg == pps_pkg::PPS_DS_DISABLED && store_valid_o && !take |=> store_valid_o && !ds_upload_o; endproperty
  a_keep: assert property (p_keep) else $error("disabled mode lost store");
  property p_none; $rose(dev_connect_i) && val_reg == pps_pkg::PPS_VAL_NONE |=> pd_start_o; endproperty
  a_none: assert property (p_none) else $error("start without validation missing");
endmodule
bind pps_port_ctrl pps_port_ctrl_chk #(.PD_BYTES(PD_BYTES)) pps_port_ctrl_chk_inst (.mclk_i, .nrst_i, .cfg_ds_mode_i,
  .cfg_val_mode_i, .cfg_fs_mode_i, .cfg_com_mode_i, .cfg_repl_i, .cfg_load_i, .dev_connect_i, .dev_valid_i,
  .dev_upload_request_flag_i, .dev_locked_i, .dev_data_differs_i, .ctl_valid_i, .ctl_pd_out_i, .master_status_i,
  .ds_upload_o, .ds_download_o, .store_valid_o, .pd_start_o, .pd_out_o, .pd_out_invalid_o, .sc_in_o);
`default_nettype wire

// ===== pps_port_ctrl_test.sv
/*
  testbench for pps_port_ctrl: storage, validation, fail-safe and image.
  assumes: pps_dev_model stands in for the device, PD_BYTES set to 4.
*/
`timescale 1ns/1ps
`default_nettype none
module pps_port_ctrl_test;
  logic clk, rst_n = 0, com = 0, grp = 0, ld = 0, conn = 0, dvalid = 0, locked = 0, differs = 0;
  logic aw = 0, cv = 0, blk = 0;
  logic [2:0] ds = 0, fs = 0;
  logic [1:0] val = 0;
  logic [7:0] vh = 0, vl = 0, dh = 0, dl = 0, pa = 0, pb = 0, doa, dob;
  logic [127:0] cser = 0, dser = "SERIAL-NUM-00042";
  logic [31:0] repl = 32'h8421F00F, ctl_pd = 0, ctl_sc = 0, acyc = 0, pdo, sci;
  logic [15:0] mstat = 0, vend, devid;
  logic [3:0] lag = 0;
  logic up, dn, sv, nv, st, vf, inv, flag, done;
  int mismatches = 0, check_count = 0;
  pps_port_ctrl #(.PD_BYTES(4)) pps_port_ctrl_inst (.mclk_i(clk), .nrst_i(rst_n), .cfg_ds_mode_i(ds),
    .cfg_val_mode_i(val), .cfg_fs_mode_i(fs), .cfg_com_mode_i(com), .cfg_grouped_i(grp), .cfg_vendor_hi_i(vh),
    .cfg_vendor_lo_i(vl), .cfg_devid_hi_i(dh), .cfg_devid_lo_i(dl), .cfg_serial_i(cser), .cfg_repl_i(repl),
    .cfg_load_i(ld), .dev_connect_i(conn), .dev_vendor_i(vend), .dev_devid_i(devid), .dev_serial_i(dser),
    .dev_valid_i(dvalid), .dev_upload_request_flag_i(flag), .dev_locked_i(locked), .dev_data_differs_i(differs),
    .ds_done_i(done), .acyc_wr_i(aw), .acyc_index_i(acyc[31:16]), .acyc_subindex_i(acyc[15:8]),
    .acyc_value_i(acyc[7:0]), .ctl_valid_i(cv), .ctl_pd_out_i(ctl_pd), .ctl_sc_out_i(ctl_sc), .pin_ch_a_i(pa),
    .pin_ch_b_i(pb), .master_status_i(mstat), .ds_upload_o(up), .ds_download_o(dn), .store_valid_o(sv), .store_nv_o(nv),
    .pd_start_o(st), .val_fail_o(vf), .pd_out_o(pdo), .pd_out_invalid_o(inv), .sc_in_o(sci), .do_ch_a_o(doa),
    .do_ch_b_o(dob));
  pps_dev_model pps_dev_model_inst (.mclk_i(clk), .nrst_i(rst_n), .blk_wr_i(blk), .busy_i(up | dn),
    .lag_i(lag), .vendor_o(vend), .devid_o(devid), .flag_o(flag), .done_o(done));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic load(input logic [2:0] d, input logic [1:0] v, input logic [2:0] f, input logic c);
    {ds, val, fs, com} = {d, v, f, c};
    ld = 1;
    tick(1);
    ld = 0;
    tick(1);
  endtask
  // wait for a request, check its kind, let the model finish it
  task automatic req(input logic eu, input logic ed);
    int i;
    for (i = 0; i < 4 && up !== 1'b1 && dn !== 1'b1; i++) tick(1);
    chk({up, dn}, {eu, ed});
    for (i = 0; i < 30 && (up === 1'b1 || dn === 1'b1); i++) tick(1);
    if (i == 30) begin
      mismatches++;
      wrap_up();
    end
  endtask
  task automatic xfer(input logic eu, input logic ed);
    conn = 1;
    req(eu, ed);
  endtask
  task automatic unplug();
    conn = 0;
    tick(2);
  endtask
  task automatic pulse_acyc(input logic [31:0] v);
    acyc = v;
    aw = 1;
    tick(1);
    aw = 0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_store();
    chk(sv, 0);
    dvalid = 1;
    differs = 1;
    load(3'h2, 2'h0, 3'h0, 0);
    xfer(1, 0);
    tick(1);
    chk({sv, nv}, 2'b10);
    unplug();
    xfer(0, 0);
    pulse_acyc(32'h00020004);
    req(0, 0);
    pulse_acyc(32'h00030005);
    req(0, 0);
    pulse_acyc(32'h00020105);
    req(0, 0);
    pulse_acyc(32'h00020005);
    req(1, 0);
    unplug();
    lag = 4'h6;
    load(3'h3, 2'h0, 3'h0, 0);
    xfer(0, 1);
    unplug();
    locked = 1;
    xfer(0, 0);
    blk = 1;
    tick(1);
    blk = 0;
    req(1, 0);
    tick(1);
    chk(nv, 1);
    unplug();
    locked = 0;
    load(3'h0, 2'h0, 3'h0, 0);
    chk(sv, 1);
    xfer(0, 0);
    unplug();
    load(3'h4, 2'h0, 3'h0, 0);
    tick(1);
    chk(sv, 0);
    load(3'h1, 2'h0, 3'h0, 0);
    xfer(0, 0);
    unplug();
    load(3'h2, 2'h0, 3'h0, 0);
    xfer(1, 0);
    unplug();
    load(3'h1, 2'h0, 3'h0, 0);
    xfer(0, 1);
    unplug();
  endtask
  task automatic s_valid();
    logic e;
    for (int n = 0; n < 5; n++) begin
      vh = vend[15:8];
      vl = (n == 0) ? ~vend[7:0] : vend[7:0];
      dh = devid[15:8];
      dl = (n == 2) ? ~devid[7:0] : devid[7:0];
      cser = (n == 1 || n == 3) ? ~dser : dser;
      e = (n != 2 && n != 3);
      load(3'h0, (n == 0) ? 2'h0 : (n < 3) ? 2'h1 : 2'h2, 3'h0, 0);
      conn = 1;
      tick(3);
      chk({st, vf}, {e, !e});
      unplug();
    end
  endtask
  task automatic s_fs();
    logic [31:0] e [5];
    e = '{32'h0, 32'hFFFFFFFF, 32'hC0FFEE11, 32'h8421F00F, 32'hC0FFEE11};
    for (int k = 0; k < 5; k++) begin
      load(3'h0, 2'h0, k[2:0], 1);
      {cv, ctl_pd} = {1'b1, 32'hC0FFEE11};
      tick(2);
      chk(pdo, ctl_pd);
      {cv, ctl_pd} = 33'h0;
      tick(2);
      chk(pdo, e[k]);
      chk(inv, k == 4);
    end
    conn = 1;
    load(3'h0, 2'h0, 3'h1, 1);
    chk(inv, 1);
    unplug();
    load(3'h0, 2'h0, 3'h1, 0);
    {cv, ctl_pd} = {1'b1, 32'hC0FFEE11};
    tick(2);
    chk(pdo, 0);
  endtask
  task automatic s_img();
    logic [15:0] e;
    logic [7:0] ea, eb;
    pa = 8'hA5;
    pb = 8'h3C;
    mstat = 16'hBEEF;
    ctl_sc = 32'h00009C63;
    for (int g = 0; g < 2; g++) begin
      grp = g[0];
      for (int p = 0; p < 8; p++) begin
        e[g ? p : 2 * p] = pa[p];
        e[g ? p + 8 : 2 * p + 1] = pb[p];
        ea[p] = ctl_sc[g ? p : 2 * p];
        eb[p] = ctl_sc[g ? p + 8 : 2 * p + 1];
      end
      tick(4);
      chk(sci, {mstat, e});
      chk({dob, doa}, {eb, ea});
    end
  endtask
  // clock, reset, sequence
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  initial begin
    tick(5);
    rst_n = 1;
    tick(1);
    s_store();
    s_valid();
    s_fs();
    s_img();
    wrap_up();
  end
endmodule
`default_nettype wire
